// ==== design/smw_pkg.sv ====
package smw_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_FLAGS = 10'h00d;
  localparam logic [9:0] IDX_ENABLES = 10'h08d;
  localparam logic [9:0] IDX_DATA_LO = 10'h10c;
  localparam logic [9:0] IDX_ADDR_LO = 10'h10d;
  localparam logic [9:0] IDX_DATA_HI = 10'h10e;
  localparam logic [9:0] IDX_ADDR_HI = 10'h10f;
  localparam logic [9:0] IDX_CONTROL = 10'h18c;
  localparam logic [9:0] IDX_UNLOCK = 10'h18d;
  // bit positions
  localparam int B_IRQ = 4;
  localparam int B_PGD = 7;
  localparam int B_FREE = 4;
  localparam int B_WERR = 3;
  localparam int B_WEL = 2;
  localparam int B_WR = 1;
  localparam int B_RD = 0;
  // unlock keys and buffer fill
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [13:0] BUF_ERASED = 14'h3fff;
  localparam logic [1:0] LAST_SLOT = 2'h3;
  // region limits: self-writes below the limit are inhibited
  localparam logic [10:0] LIM_NONE = 11'h000;
  localparam logic [10:0] LIM_LOW = 11'h100;
  localparam logic [10:0] LIM_MID = 11'h200;
  localparam logic [10:0] LIM_ALL = 11'h7ff;
  // power-up timer
  localparam int PUT_MS = 72;
  localparam int CLK_KHZ = 250000;
  localparam int PUT_CYCLES = PUT_MS * CLK_KHZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHORT = 3'b001,
    ST_RD1 = 3'b010,
    ST_RD2 = 3'b011,
    ST_BUSY = 3'b100
  } smw_st_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PRD = 3'b001,
    OP_PWR4 = 3'b010,
    OP_ERASE = 3'b011,
    OP_ERD = 3'b100,
    OP_EWR = 3'b101
  } smw_op_type;

  // request to the memory arrays
  typedef struct packed {
    logic go;
    smw_op_type op;
    logic [10:0] addr;
    logic [55:0] wdata;
  } smw_req_type;

  typedef struct packed {
    logic awh;
    logic [11:0] awa;
    logic wh;
    logic [7:0] wd;
    logic wst;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [7:0] rd;
    logic [1:0] rr;
    logic [7:0] dlo;
    logic [7:0] alo;
    logic [5:0] dhi;
    logic [2:0] ahi;
    logic pgd;
    logic free;
    logic werr;
    logic write_enable_latch;
    logic wr;
    logic rdb;
    logic memop_irq_flag;
    logic memop_irq_enable;
    logic [1:0] key;
    logic [55:0] wbuf;
    smw_st_type st;
    logic [24:0] put;
    smw_req_type req;
  } smw_state_type;
endpackage

// ==== design/smw_ctrl.sv ====
`timescale 1ns/100ps
module smw_ctrl #(
  parameter int PUT_COUNT = smw_pkg::PUT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory arrays
  output smw_pkg::smw_req_type mem_req,
  input wire logic mem_done,
  input wire logic [13:0] mem_rdata,
  // configuration word and system
  input wire logic [1:0] region_write_protect,
  input wire logic cp_data,
  input wire logic cp_prog,
  input wire logic sys_rst_req,
  // processor and external port
  output logic cpu_skip,
  output logic irq,
  output logic ext_ee_ok,
  output logic ext_prog_rd_ok,
  output logic ext_prog_wr_ok
);

  smw_pkg::smw_state_type s_r;
  smw_pkg::smw_state_type s_nxt;
  logic do_wr;
  logic do_rd;
  logic [9:0] widx;
  logic [9:0] ridx;
  logic [10:0] wad;
  logic [13:0] word;

  // region check against the configured limit
  function automatic logic is_prot(input logic [1:0] rg,
                                   input logic [10:0] a);
    logic [10:0] lim;
    case (rg)
      2'b00: lim = smw_pkg::LIM_ALL;
      2'b01: lim = smw_pkg::LIM_MID;
      2'b10: lim = smw_pkg::LIM_LOW;
      default: lim = smw_pkg::LIM_NONE;
    endcase
    return (rg == 2'b00) || (a < lim);
  endfunction

  assign do_wr = s_r.awh && s_r.wh && !s_r.bv;
  assign do_rd = s_axi_arvalid && !s_r.rv;
  assign widx = s_r.awa[11:2];
  assign ridx = s_axi_araddr[11:2];
  assign wad = {s_r.ahi, s_r.alo};
  assign word = {s_r.dhi, s_r.dlo};

  // next-state logic for bus, registers and sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.req.go = 1'b0;
    if (s_r.put != 25'h0) begin
      s_nxt.put = s_r.put - 25'h1;
    end
    // bus capture
    if (s_axi_awvalid && !s_r.awh) begin
      s_nxt.awh = 1'b1;
      s_nxt.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.wh) begin
      s_nxt.wh = 1'b1;
      s_nxt.wd = s_axi_wdata[7:0];
      s_nxt.wst = s_axi_wstrb[0];
    end
    if (s_r.bv && s_axi_bready) begin
      s_nxt.bv = 1'b0;
    end
    if (s_r.rv && s_axi_rready) begin
      s_nxt.rv = 1'b0;
    end
    // sequencer progress
    case (s_r.st)
      smw_pkg::ST_SHORT: begin
        s_nxt.wr = 1'b0;
        s_nxt.st = smw_pkg::ST_IDLE;
      end
      smw_pkg::ST_RD1: begin
        s_nxt.req.go = 1'b1;
        s_nxt.st = smw_pkg::ST_RD2;
      end
      smw_pkg::ST_RD2: begin
        s_nxt.dlo = mem_rdata[7:0];
        if (s_r.pgd) begin
          s_nxt.dhi = mem_rdata[13:8];
        end
        s_nxt.rdb = 1'b0;
        s_nxt.st = smw_pkg::ST_IDLE;
      end
      smw_pkg::ST_BUSY: begin
        if (mem_done) begin
          s_nxt.wr = 1'b0;
          s_nxt.memop_irq_flag = 1'b1;
          s_nxt.st = smw_pkg::ST_IDLE;
          if (s_r.req.op == smw_pkg::OP_PWR4) begin
            s_nxt.wbuf = {4{smw_pkg::BUF_ERASED}};
          end
        end
      end
      default: s_nxt.st = smw_pkg::ST_IDLE;
    endcase
    // register write
    if (do_wr) begin
      s_nxt.awh = 1'b0;
      s_nxt.wh = 1'b0;
      s_nxt.bv = 1'b1;
      s_nxt.br = smw_pkg::RESP_OKAY;
      // any other write with byte strobe 0 set breaks the key sequence
      if (s_r.wst) begin
        s_nxt.key = 2'd0;
      end
      case (widx)
        smw_pkg::IDX_FLAGS: begin
          // completion in the same cycle wins over the clear
          if (s_r.wst && s_r.wd[smw_pkg::B_IRQ]
              && !(mem_done && s_r.st == smw_pkg::ST_BUSY)) begin
            s_nxt.memop_irq_flag = 1'b0;
          end
        end
        smw_pkg::IDX_ENABLES: begin
          if (s_r.wst) begin
            s_nxt.memop_irq_enable = s_r.wd[smw_pkg::B_IRQ];
          end
        end
        smw_pkg::IDX_DATA_LO: if (s_r.wst) s_nxt.dlo = s_r.wd;
        smw_pkg::IDX_ADDR_LO: if (s_r.wst) s_nxt.alo = s_r.wd;
        smw_pkg::IDX_DATA_HI: if (s_r.wst) s_nxt.dhi = s_r.wd[5:0];
        smw_pkg::IDX_ADDR_HI: if (s_r.wst) s_nxt.ahi = s_r.wd[2:0];
        smw_pkg::IDX_UNLOCK: begin
          if (s_r.wst && s_r.wd == smw_pkg::KEY_FIRST) begin
            s_nxt.key = 2'd1;
          end else if (s_r.wst && s_r.wd == smw_pkg::KEY_SECOND
                       && s_r.key == 2'd1) begin
            s_nxt.key = 2'd2;
          end
        end
        smw_pkg::IDX_CONTROL: begin
          if (s_r.wst && s_r.st == smw_pkg::ST_IDLE) begin
            s_nxt.pgd = s_r.wd[smw_pkg::B_PGD];
            s_nxt.free = s_r.wd[smw_pkg::B_FREE];
            s_nxt.write_enable_latch = s_r.wd[smw_pkg::B_WEL];
            s_nxt.werr = s_r.wd[smw_pkg::B_WERR];
            s_nxt.req.addr = wad;
            if (s_r.wd[smw_pkg::B_RD]) begin
              s_nxt.rdb = 1'b1;
              s_nxt.st = smw_pkg::ST_RD1;
              s_nxt.req.op = s_r.wd[smw_pkg::B_PGD] ?
                             smw_pkg::OP_PRD : smw_pkg::OP_ERD;
            end else if (s_r.wd[smw_pkg::B_WR]
                         && s_r.wd[smw_pkg::B_WEL]
                         && s_r.key == 2'd2) begin
              if (!s_r.wd[smw_pkg::B_PGD]) begin
                if (s_r.put == 25'h0) begin
                  s_nxt.wr = 1'b1;
                  s_nxt.st = smw_pkg::ST_BUSY;
                  s_nxt.req.go = 1'b1;
                  s_nxt.req.op = smw_pkg::OP_EWR;
                  s_nxt.req.wdata = {48'h0, s_r.dlo};
                end
              end else if (!is_prot(region_write_protect, wad)) begin
                s_nxt.wr = 1'b1;
                if (s_r.wd[smw_pkg::B_FREE]) begin
                  s_nxt.st = smw_pkg::ST_BUSY;
                  s_nxt.req.go = 1'b1;
                  s_nxt.req.op = smw_pkg::OP_ERASE;
                  s_nxt.req.addr = {wad[10:5], 5'h00};
                end else begin
                  s_nxt.wbuf[14*s_r.alo[1:0] +: 14] = word;
                  s_nxt.st = smw_pkg::ST_SHORT;
                  if (s_r.alo[1:0] == smw_pkg::LAST_SLOT) begin
                    s_nxt.st = smw_pkg::ST_BUSY;
                    s_nxt.req.go = 1'b1;
                    s_nxt.req.op = smw_pkg::OP_PWR4;
                    s_nxt.req.addr = {wad[10:2], 2'b00};
                    s_nxt.req.wdata = {word, s_r.wbuf[41:0]};
                  end
                end
              end
            end
          end
        end
        default: s_nxt.br = smw_pkg::RESP_SLVERR;
      endcase
    end
    // reset abort flags error, wins over software
    if (sys_rst_req) begin
      if (s_r.st == smw_pkg::ST_BUSY) begin
        s_nxt.werr = 1'b1;
      end
      s_nxt.wr = 1'b0;
      s_nxt.rdb = 1'b0;
      s_nxt.write_enable_latch = 1'b0;
      s_nxt.req.go = 1'b0; // no request escapes an aborted start
      s_nxt.key = 2'd0;
      s_nxt.st = smw_pkg::ST_IDLE;
    end
    // register read
    if (do_rd) begin
      s_nxt.rv = 1'b1;
      s_nxt.rr = smw_pkg::RESP_OKAY;
      case (ridx)
        smw_pkg::IDX_FLAGS: s_nxt.rd = {3'h0, s_r.memop_irq_flag, 4'h0};
        smw_pkg::IDX_ENABLES: s_nxt.rd = {3'h0, s_r.memop_irq_enable, 4'h0};
        smw_pkg::IDX_DATA_LO: s_nxt.rd = s_r.dlo;
        smw_pkg::IDX_ADDR_LO: s_nxt.rd = s_r.alo;
        smw_pkg::IDX_DATA_HI: s_nxt.rd = {2'h0, s_r.dhi};
        smw_pkg::IDX_ADDR_HI: s_nxt.rd = {5'h0, s_r.ahi};
        smw_pkg::IDX_CONTROL: s_nxt.rd = {s_r.pgd, 2'h0, s_r.free,
            s_r.werr, s_r.write_enable_latch, s_r.wr, s_r.rdb};
        smw_pkg::IDX_UNLOCK: s_nxt.rd = 8'h00;
        default: begin
          s_nxt.rd = 8'h00;
          s_nxt.rr = smw_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // state register; write enable cleared at power-up
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.wbuf <= {4{smw_pkg::BUF_ERASED}};
      s_r.put <= 25'(PUT_COUNT);
    end else begin
      s_r <= s_nxt;
    end
  end

  // bus outputs
  assign s_axi_awready = !s_r.awh;
  assign s_axi_wready = !s_r.wh;
  assign s_axi_bvalid = s_r.bv;
  assign s_axi_bresp = s_r.br;
  assign s_axi_arready = !s_r.rv;
  assign s_axi_rvalid = s_r.rv;
  assign s_axi_rdata = {24'h0, s_r.rd};
  assign s_axi_rresp = s_r.rr;
  assign mem_req = s_r.req;
  assign irq = s_r.memop_irq_flag && s_r.memop_irq_enable;
  assign cpu_skip = (s_r.st == smw_pkg::ST_RD2)
                    || (s_r.st == smw_pkg::ST_BUSY);
  assign ext_ee_ok = !cp_data;
  assign ext_prog_rd_ok = !cp_prog;
  assign ext_prog_wr_ok = !cp_prog && !cp_data;

  // checks
  a_key_before_go: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.req.go && s_r.req.op inside {smw_pkg::OP_PWR4,
    smw_pkg::OP_ERASE, smw_pkg::OP_EWR} |-> $past(s_r.key) == 2'd2)
    else $error("write started without unlock");
  a_put_blocks_ee: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.req.go && s_r.req.op == smw_pkg::OP_EWR |-> s_r.put == 25'h0)
    else $error("eeprom write during power-up timer");
  a_row_aligned: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.req.go && s_r.req.op == smw_pkg::OP_ERASE
    |-> s_r.req.addr[4:0] == 5'h00)
    else $error("erase row not aligned");
  a_buf_refill: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mem_done && !sys_rst_req && s_r.st == smw_pkg::ST_BUSY
    && s_r.req.op == smw_pkg::OP_PWR4
    |=> s_r.wbuf == {4{smw_pkg::BUF_ERASED}})
    else $error("buffer not refilled");
  a_short_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.st == smw_pkg::ST_SHORT |=> !s_r.wr)
    else $error("short write bit stuck");
  a_read_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.st == smw_pkg::ST_RD1 && !sys_rst_req
    |=> s_r.req.go ##1 !s_r.rdb)
    else $error("read not in second cycle");
  a_region_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.req.go && s_r.req.op inside {smw_pkg::OP_PWR4, smw_pkg::OP_ERASE}
    |-> !is_prot($past(region_write_protect), $past(wad)))
    else $error("write to inhibited region");
  a_done_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mem_done && s_r.st == smw_pkg::ST_BUSY && !sys_rst_req
    |=> s_r.memop_irq_flag && !s_r.wr)
    else $error("completion not flagged");
  a_ext_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cp_data |-> !ext_prog_wr_ok && !ext_ee_ok)
    else $error("external access not blocked");
  c_block_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.req.go && s_r.req.op == smw_pkg::OP_PWR4);
  c_erase: cover property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.req.go && s_r.req.op == smw_pkg::OP_ERASE);
  c_prog_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.st == smw_pkg::ST_RD2 && s_r.pgd);

endmodule

// ==== verification/smw_mem_model.sv ====
`timescale 1ns/100ps
// memory array stand-in: reads answer in the go cycle, writes end later
module smw_mem_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request side
  input wire smw_pkg::smw_req_type mem_req,
  input wire logic slow,
  // answers
  output logic mem_done,
  output logic [13:0] mem_rdata
);
  logic [4:0] cnt_r;
  logic [13:0] stale_r;
  logic rd_go;
  logic wr_go;

  // decode of the request kind
  assign rd_go = mem_req.go && (mem_req.op inside
    {smw_pkg::OP_PRD, smw_pkg::OP_ERD});
  assign wr_go = mem_req.go && (mem_req.op inside
    {smw_pkg::OP_PWR4, smw_pkg::OP_ERASE, smw_pkg::OP_EWR});

  // the controller latches read data at the edge that ends its go cycle
  assign mem_rdata = rd_go ? {mem_req.addr, 3'h5} : stale_r;

  // stale read data is inverted each cycle so it never passes as fresh
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
      mem_done <= 1'b0;
      stale_r <= 14'h0000;
    end else begin
      mem_done <= (cnt_r == 5'h01);
      stale_r <= ~mem_rdata;
      if (wr_go) begin
        cnt_r <= slow ? 5'h0c : 5'h01; // slow or prompt completion
      end else if (cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end
endmodule

// ==== verification/tb_self_program_memory_write_ctrl.sv ====
`timescale 1ns/100ps
module tb_self_program_memory_write_ctrl;
  localparam int PUT = 60;
  logic ref_clk, rst_n, slow, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mem_done, cp_data, cp_prog, sys_rst_req, cpu_skip, irq;
  logic ext_ee_ok, ext_prog_rd_ok, ext_prog_wr_ok;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rwp, rr, wb;
  logic [13:0] mem_rdata;
  logic [55:0] ew;
  smw_pkg::smw_req_type mem_req, last_req;
  int bad_count, check_count, go_cnt, cyc;

  smw_ctrl #(.PUT_COUNT(PUT)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .mem_req(mem_req),
    .mem_done(mem_done), .mem_rdata(mem_rdata),
    .region_write_protect(rwp), .cp_data(cp_data), .cp_prog(cp_prog),
    .sys_rst_req(sys_rst_req), .cpu_skip(cpu_skip), .irq(irq),
    .ext_ee_ok(ext_ee_ok), .ext_prog_rd_ok(ext_prog_rd_ok),
    .ext_prog_wr_ok(ext_prog_wr_ok));

  smw_mem_model mem_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .mem_req(mem_req), .slow(slow), .mem_done(mem_done),
    .mem_rdata(mem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // record each request sent to the arrays
  always @(negedge ref_clk) begin
    if (mem_req.go === 1'b1) begin
      last_req = mem_req;
      go_cnt++;
    end
  end

  // cut a hung run short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // register write; address and data offered together
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge ref_clk); while (!(s_axi_awready && s_axi_wready));
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
    wb = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] d);
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic unlock_go(input logic [7:0] c);
    wr(smw_pkg::IDX_UNLOCK, smw_pkg::KEY_FIRST);
    wr(smw_pkg::IDX_UNLOCK, smw_pkg::KEY_SECOND);
    wr(smw_pkg::IDX_CONTROL, c);
  endtask

  // poll the completion flag, then clear it
  task automatic wait_flag();
    repeat (40) begin
      rd(smw_pkg::IDX_FLAGS, rv);
      if (rv[4] === 1'b1) break;
    end
    chk("done flag", rv[4], 1'b1);
    wr(smw_pkg::IDX_FLAGS, 8'h10);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    {rst_n, slow, cp_data, cp_prog, sys_rst_req} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    rwp = 2'h3;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(smw_pkg::IDX_CONTROL, rv);
    chk("control", rv, 32'h0);
    rd(smw_pkg::IDX_FLAGS, rv);
    chk("flags", rv, 32'h0);
    rd(smw_pkg::IDX_ENABLES, rv);
    chk("enables", rv, 32'h0);
    wr(smw_pkg::IDX_DATA_LO, 8'h5a);
    unlock_go(8'h06);
    chk("early go", go_cnt, 0);
    $display("test power-up done");
    repeat (PUT) @(posedge ref_clk);
    wr(smw_pkg::IDX_CONTROL, 8'h06);
    wr(smw_pkg::IDX_UNLOCK, smw_pkg::KEY_FIRST);
    wr(smw_pkg::IDX_DATA_LO, 8'h5a);
    wr(smw_pkg::IDX_UNLOCK, smw_pkg::KEY_SECOND);
    wr(smw_pkg::IDX_CONTROL, 8'h06);
    chk("locked go", go_cnt, 0);
    rd(smw_pkg::IDX_UNLOCK, rv);
    chk("unlock read", rv, 32'h0);
    chk("write resp", wb, smw_pkg::RESP_OKAY);
    unlock_go(8'h06);
    chk("eeprom op", last_req.op, smw_pkg::OP_EWR);
    chk("eeprom data", last_req.wdata[7:0], 8'h5a);
    wait_flag();
    chk("irq masked", irq, 1'b0);
    wr(smw_pkg::IDX_ENABLES, 8'h10);
    wr(smw_pkg::IDX_FLAGS, 8'h00);
    $display("test unlock done");
    // block at an erased, aligned row start
    wr(smw_pkg::IDX_ADDR_HI, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(smw_pkg::IDX_ADDR_LO, 8'(i));
      wr(smw_pkg::IDX_DATA_LO, 8'(160 + i));
      wr(smw_pkg::IDX_DATA_HI, 8'(17 + i));
      unlock_go(8'h86);
      ew[14*i +: 14] = {6'(17 + i), 8'(160 + i)};
      chk("block go", go_cnt, (i < 3) ? 1 : 2);
    end
    chk("block op", last_req.op, smw_pkg::OP_PWR4);
    chk("block addr", last_req.addr, 11'h100);
    chk("block data", last_req.wdata, ew);
    repeat (40) @(posedge ref_clk);
    chk("irq set", irq, 1'b1);
    wait_flag();
    chk("irq clear", irq, 1'b0);
    // lone last word shows the refilled buffer
    wr(smw_pkg::IDX_ADDR_LO, 8'h03);
    unlock_go(8'h86);
    chk("refill", last_req.wdata, {14'h14a3, {3{14'h3fff}}});
    wait_flag();
    $display("test block done");
    @(posedge ref_clk);
    rwp <= 2'h2;
    slow <= 1'b1;
    wr(smw_pkg::IDX_ADDR_HI, 8'h00);
    wr(smw_pkg::IDX_ADDR_LO, 8'hab);
    unlock_go(8'h96);
    chk("guarded go", go_cnt, 3);
    wr(smw_pkg::IDX_ADDR_HI, 8'h01);
    unlock_go(8'h96);
    chk("erase op", last_req.op, smw_pkg::OP_ERASE);
    chk("erase addr", last_req.addr, 11'h1a0);
    @(negedge ref_clk);
    chk("erase stall", cpu_skip, 1'b1);
    @(posedge ref_clk);
    sys_rst_req <= 1'b1;
    @(posedge ref_clk);
    sys_rst_req <= 1'b0;
    do @(negedge ref_clk); while (mem_done !== 1'b1);
    rd(smw_pkg::IDX_CONTROL, rv);
    chk("abort control", rv, 32'h98);
    chk("stall end", cpu_skip, 1'b0);
    $display("test erase done");
    wr(smw_pkg::IDX_ADDR_LO, 8'h23);
    wr(smw_pkg::IDX_CONTROL, 8'h81);
    @(posedge ref_clk);
    chk("read op", {last_req.op, last_req.addr}, {3'h1, 11'h123});
    rd(smw_pkg::IDX_DATA_LO, rv);
    chk("read low", rv, 32'h1d);
    rd(smw_pkg::IDX_DATA_HI, rv);
    chk("read high", rv, 32'h09);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      cp_data <= k[1];
      cp_prog <= k[0];
      @(negedge ref_clk);
      chk("ext gates", {ext_ee_ok, ext_prog_rd_ok, ext_prog_wr_ok},
          {!k[1], !k[0], k == 0});
    end
    // internal eeprom read still works under both protections
    wr(smw_pkg::IDX_ADDR_LO, 8'h40);
    wr(smw_pkg::IDX_CONTROL, 8'h01);
    @(posedge ref_clk);
    chk("ee read op", last_req.op, smw_pkg::OP_ERD);
    rd(smw_pkg::IDX_DATA_LO, rv);
    chk("ee read low", rv, 32'h05);
    rd(smw_pkg::IDX_DATA_HI, rv);
    chk("ee read high", rv, 32'h09);
    rd(10'h001, rv);
    chk("unmapped", {rr, rv}, {smw_pkg::RESP_SLVERR, 32'h0});
    wr(10'h001, 8'h00);
    chk("unmapped write", wb, smw_pkg::RESP_SLVERR);
    $display("test read and protect done");
    give_verdict();
  end
endmodule
